// ==== rtl/asp_params.svh ====
// Constants for the alarm status and power mode block: register offsets,
// reset values, field positions and serial frame layout.
// Assumes a 15-bit register address carried in a 24-bit serial frame.
`ifndef ASP_PARAMS_SVH
`define ASP_PARAMS_SVH

// Register offsets on the configuration serial port
`define ASP_ADDR_LP_C        15'h029b
`define ASP_ADDR_LP_D        15'h029c
`define ASP_ADDR_SUMMARY     15'h02c0
`define ASP_ADDR_FLAGS       15'h02c1
`define ASP_ADDR_MASK        15'h02c2
`define ASP_ADDR_LANE        15'h02c4

// Reset values
`define ASP_RST_LP_C         8'h04
`define ASP_RST_LP_D         8'h1b
`define ASP_RST_FLAGS        6'h3f
`define ASP_RST_MASK         8'h3f
`define ASP_RST_LANE         8'hff

// Power setting codes
`define ASP_LP_C_LOW         8'h00
`define ASP_LP_C_HIGH        8'h04
`define ASP_LP_D_LOW         8'h14
`define ASP_LP_D_HIGH        8'h1b

// Alarm flag bit positions
`define ASP_BIT_FIFO         5
`define ASP_BIT_PLL          4
`define ASP_BIT_LINK         3
`define ASP_BIT_REALIGN      2
`define ASP_BIT_RSVD         1
`define ASP_BIT_CLK          0

// Serial frame: bit counts before the last address bit and before the last bit
`define ASP_CMD_LAST         5'd15
`define ASP_FRAME_LAST       5'd23
`define ASP_LANES            8

`endif

// ==== rtl/asp_pkg.sv ====
// Types shared by the alarm status and power mode block.
// Assumes asp_params.svh supplies all numeric constants.
package asp_pkg;

  // Serial port frame phase, one-hot
  typedef enum logic [2:0]
  {
    ASP_IDLE = 3'b001,
    ASP_CMD  = 3'b010,
    ASP_DATA = 3'b100
  } asp_spi_state_type;

endpackage

// ==== rtl/asp_alarm_power.sv ====
// Alarm collection, alarm summary and power mode setting registers,
// reached over the configuration serial port (mode 0, 24-bit frames:
// read flag, 15-bit address, 8-bit data, MSB first).
// Assumes alarm condition inputs come from logic on mclk_in; serial pins
// come from outside and are synchronised here.
`timescale 1ns/10ps
`include "asp_params.svh"

module asp_alarm_power
  import asp_pkg::*;
(
  // Clock and resets
  input  wire logic                   mclk_in,
  input  wire logic                   resetn_in,
  input  wire logic                   soft_reset_in,
  // Configuration serial port
  input  wire logic                   spi_sclk_in,
  input  wire logic                   spi_csn_in,
  input  wire logic                   spi_sdi_in,
  output logic                        spi_sdo_out,
  output logic                        spi_sdo_oen_n_out,
  // Alarm conditions
  input  wire logic [`ASP_LANES-1:0]  lane_fifo_error_in,
  input  wire logic                   spll_locked_in,
  input  wire logic                   serial_link_enable_in,
  input  wire logic                   link_mode_64b66b_in,
  input  wire logic                   link_data_phase_in,
  input  wire logic                   link_realign_in,
  input  wire logic                   clock_realign_in,
  input  wire logic                   divider_mismatch_in,
  // Calibration status pin
  input  wire logic                   cal_status_alarm_sel_in,
  input  wire logic                   cal_status_in,
  output logic                        calibration_status_pin_out,
  // Power mode setting codes
  output logic [7:0]                  power_setting_code_c_out,
  output logic [7:0]                  power_setting_code_d_out
);

  import asp_pkg::*;

  // Serial pin synchronisers; sclk has a third stage for edge detection
  logic              sclk_s1_reg;
  logic              sclk_s2_reg;
  logic              sclk_s3_reg;
  logic              csn_s1_reg;
  logic              csn_s2_reg;
  logic              sdi_s1_reg;
  logic              sdi_s2_reg;
  logic              sclk_rise;
  logic              sclk_fall;

  // Serial frame state
  asp_spi_state_type state_reg,    state_next;
  logic [4:0]        cnt_reg,      cnt_next;
  logic [15:0]       shift_reg,    shift_next;
  logic [14:0]       addr_reg,     addr_next;
  logic              rd_reg,       rd_next;
  logic [7:0]        rdsh_reg,     rdsh_next;
  logic              sdo_reg,      sdo_next;
  logic              oen_n_reg,    oen_n_next;
  logic              wr_reg,       wr_next;
  logic [7:0]        wdata_reg,    wdata_next;
  logic [15:0]       cmd_full;
  logic [7:0]        rd_mux;

  // Register file and alarm state
  logic [7:0]        lp_c_reg,     lp_c_next;
  logic [7:0]        lp_d_reg,     lp_d_next;
  logic [7:0]        mask_reg,     mask_next;
  logic [5:0]        flags_reg,    flags_next;
  logic [7:0]        lane_reg,     lane_next;
  logic              sum_reg,      sum_next;
  logic              pin_reg,      pin_next;
  logic              link_en_d_reg;
  logic [5:0]        cond;
  logic [5:0]        flag_clr;
  logic [7:0]        lane_clr;

  // Synchronisers: first stages feed only the second stages
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sclk_s1_reg <= 1'b0;
      sclk_s2_reg <= 1'b0;
      sclk_s3_reg <= 1'b0;
      csn_s1_reg  <= 1'b1;
      csn_s2_reg  <= 1'b1;
      sdi_s1_reg  <= 1'b0;
      sdi_s2_reg  <= 1'b0;
    end
    else
    begin
      sclk_s1_reg <= spi_sclk_in;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_s3_reg <= sclk_s2_reg;
      csn_s1_reg  <= spi_csn_in;
      csn_s2_reg  <= csn_s1_reg;
      sdi_s1_reg  <= spi_sdi_in;
      sdi_s2_reg  <= sdi_s1_reg;
    end
  end

  assign sclk_rise = sclk_s2_reg & ~sclk_s3_reg;
  assign sclk_fall = ~sclk_s2_reg & sclk_s3_reg;
  assign cmd_full  = {shift_reg[14:0], sdi_s2_reg};

  // Read data selection; unused upper bits of summary and flags read as zero, mask bits 7:6 and reserved flag bit 1 read as stored.
  // Keyed on the latched address so that it never feeds back into the sequencer.
  always_comb
  begin
    case (addr_reg)
      `ASP_ADDR_LP_C:    rd_mux = lp_c_reg;
      `ASP_ADDR_LP_D:    rd_mux = lp_d_reg;
      `ASP_ADDR_SUMMARY: rd_mux = {7'h00, sum_reg};
      `ASP_ADDR_FLAGS:   rd_mux = {2'b00, flags_reg};
      `ASP_ADDR_MASK:    rd_mux = mask_reg;
      `ASP_ADDR_LANE:    rd_mux = lane_reg;
      default:           rd_mux = 8'h00;
    endcase
  end

  // Serial frame sequencing; sample on rising sclk, drive on falling sclk.
  // The pin must be oversampled: sclk must stay below about mclk/6.
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    shift_next = shift_reg;
    addr_next  = addr_reg;
    rd_next    = rd_reg;
    rdsh_next  = rdsh_reg;
    sdo_next   = sdo_reg;
    oen_n_next = oen_n_reg;
    wr_next    = 1'b0;
    wdata_next = wdata_reg;
    if (csn_s2_reg)
    begin
      // Deselected: abandon any partial frame, release the data pin
      state_next = ASP_IDLE;
      cnt_next   = 5'd0;
      oen_n_next = 1'b1;
    end
    else
    begin
      case (state_reg)
        ASP_IDLE:
        begin
          state_next = ASP_CMD;
          cnt_next   = 5'd0;
        end
        ASP_CMD:
        begin
          if (sclk_rise)
          begin
            shift_next = cmd_full;
            cnt_next   = cnt_reg + 5'd1;
            if (cnt_reg == `ASP_CMD_LAST)
            begin
              // Address complete: latch it and fetch read data
              addr_next  = cmd_full[14:0];
              rd_next    = cmd_full[15];
              state_next = ASP_DATA;
            end
          end
        end
        ASP_DATA:
        begin
          // Load once, before the first fall drives the pin; a later reload
          // would undo the first shift and repeat the top bit
          if (cnt_reg == `ASP_CMD_LAST + 5'd1 && oen_n_reg && !sclk_rise && !sclk_fall)
            rdsh_next = rd_mux;
          if (sclk_rise && cnt_reg <= `ASP_FRAME_LAST)
          begin
            shift_next = cmd_full;
            cnt_next   = cnt_reg + 5'd1;
            if (cnt_reg == `ASP_FRAME_LAST && !rd_reg)
            begin
              wr_next    = 1'b1;
              wdata_next = cmd_full[7:0];
            end
          end
          if (sclk_fall && rd_reg && cnt_reg <= `ASP_FRAME_LAST)
          begin
            sdo_next   = rdsh_reg[7];
            rdsh_next  = {rdsh_reg[6:0], 1'b0};
            oen_n_next = 1'b0;
          end
        end
        default:
          state_next = ASP_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_reg <= ASP_IDLE;
      cnt_reg   <= 5'd0;
      shift_reg <= 16'h0000;
      addr_reg  <= 15'h0000;
      rd_reg    <= 1'b0;
      rdsh_reg  <= 8'h00;
      sdo_reg   <= 1'b0;
      oen_n_reg <= 1'b1;
      wr_reg    <= 1'b0;
      wdata_reg <= 8'h00;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      shift_reg <= shift_next;
      addr_reg  <= addr_next;
      rd_reg    <= rd_next;
      rdsh_reg  <= rdsh_next;
      sdo_reg   <= sdo_next;
      oen_n_reg <= oen_n_next;
      wr_reg    <= wr_next;
      wdata_reg <= wdata_next;
    end
  end

  // Alarm conditions, one per flag position; reserved bit 1 stays zero
  always_comb
  begin
    cond                = 6'h00;
    cond[`ASP_BIT_FIFO] = |lane_fifo_error_in;
    cond[`ASP_BIT_PLL]  = ~spll_locked_in;
    // Link alarm depends on encoding; start-up is the enable rising
    if (link_mode_64b66b_in)
      cond[`ASP_BIT_LINK] = link_realign_in |
                            (serial_link_enable_in & ~link_en_d_reg);
    else
      cond[`ASP_BIT_LINK] = serial_link_enable_in & ~link_data_phase_in;
    cond[`ASP_BIT_REALIGN] = clock_realign_in;
    cond[`ASP_BIT_CLK]     = divider_mismatch_in;
    // Other flags are simply left running while the link is off
  end

  // Register writes and sticky alarm flags; set wins over clear
  always_comb
  begin
    lp_c_next = lp_c_reg;
    lp_d_next = lp_d_reg;
    mask_next = mask_reg;
    flag_clr  = 6'h00;
    lane_clr  = 8'h00;
    if (wr_reg)
    begin
      case (addr_reg)
        `ASP_ADDR_LP_C:  lp_c_next = wdata_reg;
        `ASP_ADDR_LP_D:  lp_d_next = wdata_reg;
        `ASP_ADDR_MASK:  mask_next = wdata_reg;
        `ASP_ADDR_FLAGS: flag_clr  = wdata_reg[5:0];
        `ASP_ADDR_LANE:  lane_clr  = wdata_reg;
        default:         lane_clr  = 8'h00;
      endcase
    end
    if (flag_clr[`ASP_BIT_FIFO])
      lane_clr = 8'hff;
    flags_next = (flags_reg & ~flag_clr) | cond;
    lane_next  = (lane_reg & ~lane_clr) | lane_fifo_error_in;
    sum_next   = |(flags_reg & ~mask_reg[5:0]);
    pin_next   = cal_status_alarm_sel_in ? sum_reg : cal_status_in;
  end

  // Soft reset restores the same values as power-on reset
  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      lp_c_reg      <= `ASP_RST_LP_C;
      lp_d_reg      <= `ASP_RST_LP_D;
      mask_reg      <= `ASP_RST_MASK;
      flags_reg     <= `ASP_RST_FLAGS;
      lane_reg      <= `ASP_RST_LANE;
      sum_reg       <= 1'b0;
      pin_reg       <= 1'b0;
      link_en_d_reg <= 1'b0;
    end
    else if (soft_reset_in)
    begin
      lp_c_reg      <= `ASP_RST_LP_C;
      lp_d_reg      <= `ASP_RST_LP_D;
      mask_reg      <= `ASP_RST_MASK;
      flags_reg     <= `ASP_RST_FLAGS;
      lane_reg      <= `ASP_RST_LANE;
      sum_reg       <= 1'b0;
      pin_reg       <= 1'b0;
      link_en_d_reg <= 1'b0;
    end
    else
    begin
      lp_c_reg      <= lp_c_next;
      lp_d_reg      <= lp_d_next;
      mask_reg      <= mask_next;
      flags_reg     <= flags_next;
      lane_reg      <= lane_next;
      sum_reg       <= sum_next;
      pin_reg       <= pin_next;
      link_en_d_reg <= serial_link_enable_in;
    end
  end

  // Outputs straight from flip-flops
  assign spi_sdo_out                = sdo_reg;
  assign spi_sdo_oen_n_out          = oen_n_reg;
  assign calibration_status_pin_out = pin_reg;
  assign power_setting_code_c_out   = lp_c_reg;
  assign power_setting_code_d_out   = lp_d_reg;

  // Checks
  sequence s_write(logic [14:0] a);
    wr_reg && addr_reg == a && !soft_reset_in;
  endsequence

  a_summary_value: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !soft_reset_in |=> sum_reg == |($past(flags_reg) & ~$past(mask_reg[5:0])))
    else $error("summary bit does not follow unmasked flags");
  a_pin_route: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    cal_status_alarm_sel_in && !soft_reset_in |=> pin_reg == $past(sum_reg))
    else $error("status pin does not carry the summary");
  a_fifo_set: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    |lane_fifo_error_in |=> flags_reg[`ASP_BIT_FIFO] && lane_reg != 8'h00)
    else $error("lane fifo error did not set alarm");
  a_pll_set: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !spll_locked_in |=> flags_reg[`ASP_BIT_PLL])
    else $error("pll unlock did not set alarm");
  a_link_8b: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    !link_mode_64b66b_in && serial_link_enable_in && !link_data_phase_in
    |=> flags_reg[`ASP_BIT_LINK])
    else $error("link outside data phase did not set alarm");
  a_link_64b: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    link_mode_64b66b_in && $rose(serial_link_enable_in) |=> flags_reg[`ASP_BIT_LINK])
    else $error("link start-up did not set alarm");
  a_realign_set: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    clock_realign_in |=> flags_reg[`ASP_BIT_REALIGN])
    else $error("clock realignment did not set alarm");
  a_clock_set: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    divider_mismatch_in |=> flags_reg[`ASP_BIT_CLK])
    else $error("divider mismatch did not set alarm");
  a_flag_clear: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    s_write(`ASP_ADDR_FLAGS) ##0 (wdata_reg[`ASP_BIT_PLL] && spll_locked_in)
    |=> !flags_reg[`ASP_BIT_PLL])
    else $error("write one did not clear flag");
  a_flag_keep: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    s_write(`ASP_ADDR_FLAGS) ##0 (!wdata_reg[`ASP_BIT_CLK] && flags_reg[`ASP_BIT_CLK])
    |=> flags_reg[`ASP_BIT_CLK])
    else $error("write zero changed flag");
  a_soft_reset: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    soft_reset_in |=> flags_reg == `ASP_RST_FLAGS && mask_reg == `ASP_RST_MASK)
    else $error("soft reset did not restore alarm state");
  a_lane_clear: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    s_write(`ASP_ADDR_FLAGS) ##0 (wdata_reg[`ASP_BIT_FIFO] && lane_fifo_error_in == 8'h00)
    |=> lane_reg == 8'h00)
    else $error("fifo flag clear left lane bits set");
  a_sticky_hold: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    flags_reg[`ASP_BIT_REALIGN] && !wr_reg |=> flags_reg[`ASP_BIT_REALIGN])
    else $error("flag fell without a clear");
  a_power_write: assert property (@(posedge mclk_in) disable iff (!resetn_in)
    s_write(`ASP_ADDR_LP_C) |=> lp_c_reg == $past(wdata_reg))
    else $error("power setting c not stored");

endmodule

// ==== testbench/test_asp_alarm_power.sv ====
// Self-checking bench for the alarm status and power mode block.
// Assumes asp_params.svh for offsets; drives the serial port, alarm
// conditions and pin select from one 25 MHz clock.
`timescale 1ns/10ps
`include "asp_params.svh"

`define CHK(g, e) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      n_mismatch++; \
      $display("MISMATCH at %0t: got %h expected %h", $time, (g), (e)); \
    end \
  end

module test_asp_alarm_power;
  import asp_pkg::*;

  // Serial timing: sclk low for 8 mclk and high for 9 mclk, well above the 3 mclk floor
  localparam int HALF  = 8;
  localparam int GAP   = 8;
  localparam int LIMIT = 80000;

  // Design inputs, all given a value at time zero
  logic       mclk;
  logic       resetn        = 1'b0;
  logic       soft_reset    = 1'b0;
  logic       sclk          = 1'b0;
  logic       csn           = 1'b1;
  logic       sdi           = 1'b0;
  logic [7:0] lane_err      = 8'h00;
  logic       spll_locked   = 1'b1;
  logic       link_en       = 1'b0;
  logic       mode64        = 1'b0;
  logic       data_phase    = 1'b1;
  logic       link_realign  = 1'b0;
  logic       clock_realign = 1'b0;
  logic       div_mis       = 1'b0;
  logic       sel           = 1'b1;
  logic       cal_in        = 1'b0;
  // Design outputs
  logic       sdo;
  logic       oen_n;
  logic       pin;
  logic [7:0] code_c;
  logic [7:0] code_d;
  // Bookkeeping
  int         n_mismatch    = 0;
  int         compares      = 0;
  int         cyc           = 0;
  logic [7:0] rdat;
  // Alarm flag bit of each cause, in the order cause() numbers them
  logic [7:0] bit_tab [5]   = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h20};

  asp_alarm_power dut
  (
    .mclk_in                    (mclk),
    .resetn_in                  (resetn),
    .soft_reset_in              (soft_reset),
    .spi_sclk_in                (sclk),
    .spi_csn_in                 (csn),
    .spi_sdi_in                 (sdi),
    .spi_sdo_out                (sdo),
    .spi_sdo_oen_n_out          (oen_n),
    .lane_fifo_error_in         (lane_err),
    .spll_locked_in             (spll_locked),
    .serial_link_enable_in      (link_en),
    .link_mode_64b66b_in        (mode64),
    .link_data_phase_in         (data_phase),
    .link_realign_in            (link_realign),
    .clock_realign_in           (clock_realign),
    .divider_mismatch_in        (div_mis),
    .cal_status_alarm_sel_in    (sel),
    .cal_status_in              (cal_in),
    .calibration_status_pin_out (pin),
    .power_setting_code_c_out   (code_c),
    .power_setting_code_d_out   (code_d)
  );

  // Free-running 25 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // Prints counts and verdict, then ends the run
  task automatic finish_test();
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Hang guard: a stuck frame would otherwise run forever
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      $display("MISMATCH at %0t: run exceeded cycle limit", $time);
      finish_test();
    end
  end

  // One 24-bit frame; sdo is sampled late in the low phase, long after it settled
  task automatic spi_frame(input logic rd, input logic [14:0] addr,
                           input logic [7:0] wdata, output logic [7:0] rdata);
    logic [23:0] frame;
    frame = {rd, addr, wdata};
    rdata = 8'h00;
    @(posedge mclk);
    csn <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      @(posedge mclk);
      sclk <= 1'b0;
      sdi  <= frame[i];
      repeat (HALF) @(posedge mclk);
      if (i < 8)
        rdata[i] = sdo;
      sclk <= 1'b1;
      repeat (HALF) @(posedge mclk);
    end
    sclk <= 1'b0;
    repeat (HALF) @(posedge mclk);
    if (rd)
      `CHK(oen_n, 1'b0)
    csn <= 1'b1;
    repeat (GAP) @(posedge mclk);
  endtask

  // Register write and read wrappers
  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] unused;
    spi_frame(1'b0, a, d, unused);
  endtask

  task automatic rd(input logic [14:0] a);
    spi_frame(1'b1, a, 8'h00, rdat);
  endtask

  // Raises or drops one alarm cause; active level differs per cause
  task automatic cause(input int i, input logic v);
    case (i)
      0:       div_mis       <= v;
      1:       clock_realign <= v;
      2:       data_phase    <= ~v;
      3:       spll_locked   <= ~v;
      default: lane_err      <= v ? 8'h08 : 8'h00;
    endcase
  endtask

  task automatic test_end(input string name);
    $display("Test %s finished, %0d mismatches so far", name, n_mismatch);
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    // Reset values of every register except ASP_ADDR_LP_D, and of both power code outputs
    `CHK(code_c, 8'h04)
    `CHK(code_d, 8'h1b)
    rd(`ASP_ADDR_LP_C);
    `CHK(rdat, 8'h04)
    rd(`ASP_ADDR_FLAGS);
    `CHK(rdat, 8'h3f)
    rd(`ASP_ADDR_MASK);
    `CHK(rdat, 8'h3f)
    rd(`ASP_ADDR_SUMMARY);
    `CHK(rdat, 8'h00)
    rd(`ASP_ADDR_LANE);
    `CHK(rdat, 8'hff)
    test_end("reset_values");
    // Low power codes, read-only summary and an unmapped place.
    // Link is still off here; both settings move to low power together.
    // No conversion results are relied on afterwards, so no calibration
    wr(`ASP_ADDR_LP_C, 8'h00);
    wr(`ASP_ADDR_LP_D, 8'h14);
    `CHK(code_c, 8'h00)
    `CHK(code_d, 8'h14)
    rd(`ASP_ADDR_LP_D);
    `CHK(rdat, 8'h14)
    wr(`ASP_ADDR_SUMMARY, 8'hff);
    rd(`ASP_ADDR_SUMMARY);
    `CHK(rdat, 8'h00)
    wr(15'h0123, 8'h55);
    rd(15'h0123);
    `CHK(rdat, 8'h00)
    test_end("power_codes");
    // Link up in 8B/10B data phase, then zero-write keeps, one-write clears
    link_en <= 1'b1;
    wr(`ASP_ADDR_FLAGS, 8'h00);
    rd(`ASP_ADDR_FLAGS);
    `CHK(rdat, 8'h3f)
    wr(`ASP_ADDR_FLAGS, 8'h3f);
    rd(`ASP_ADDR_FLAGS);
    `CHK(rdat, 8'h00)
    rd(`ASP_ADDR_LANE);
    `CHK(rdat, 8'h00)
    test_end("clear_flags");
    // Each cause pulses briefly; its flag must stay, gate the summary and the pin
    for (int i = 0; i < 5; i++)
    begin
      cause(i, 1'b1);
      repeat (4) @(posedge mclk);
      cause(i, 1'b0);
      rd(`ASP_ADDR_FLAGS);
      `CHK(rdat, bit_tab[i])
      rd(`ASP_ADDR_SUMMARY);
      `CHK(rdat, 8'h00)
      wr(`ASP_ADDR_MASK, 8'h3f ^ bit_tab[i]);
      rd(`ASP_ADDR_SUMMARY);
      `CHK(rdat, 8'h01)
      `CHK(pin, 1'b1)
      if (i == 4)
      begin
        rd(`ASP_ADDR_LANE);
        `CHK(rdat, 8'h08)
      end
      wr(`ASP_ADDR_FLAGS, bit_tab[i]);
      rd(`ASP_ADDR_FLAGS);
      `CHK(rdat, 8'h00)
      `CHK(pin, 1'b0)
      wr(`ASP_ADDR_MASK, 8'h3f);
    end
    test_end("alarm_causes");
    // 64B/66B: start-up and realignment fire the link alarm, data phase does not
    link_en    <= 1'b0;
    mode64     <= 1'b1;
    data_phase <= 1'b0;
    repeat (4) @(posedge mclk);
    link_en <= 1'b1;
    rd(`ASP_ADDR_FLAGS);
    `CHK(rdat, 8'h08)
    wr(`ASP_ADDR_FLAGS, 8'h3f);
    rd(`ASP_ADDR_FLAGS);
    `CHK(rdat, 8'h00)
    link_realign <= 1'b1;
    repeat (2) @(posedge mclk);
    link_realign <= 1'b0;
    rd(`ASP_ADDR_FLAGS);
    `CHK(rdat, 8'h08)
    test_end("link_64b66b");
    // Persistent conditions set again straight after a clear
    spll_locked <= 1'b0;
    lane_err    <= 8'h01;
    repeat (4) @(posedge mclk);
    wr(`ASP_ADDR_FLAGS, 8'h3f);
    rd(`ASP_ADDR_FLAGS);
    `CHK(rdat, 8'h30)
    wr(`ASP_ADDR_LANE, 8'h01);
    rd(`ASP_ADDR_LANE);
    `CHK(rdat, 8'h01)
    spll_locked <= 1'b1;
    lane_err    <= 8'h00;
    wr(`ASP_ADDR_FLAGS, 8'h3f);
    rd(`ASP_ADDR_FLAGS);
    `CHK(rdat, 8'h00)
    rd(`ASP_ADDR_LANE);
    `CHK(rdat, 8'h00)
    test_end("persistent");
    // Pin carries the plain status when the alarm is not selected
    sel    <= 1'b0;
    cal_in <= 1'b1;
    repeat (4) @(posedge mclk);
    `CHK(pin, 1'b1)
    cal_in <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK(pin, 1'b0)
    sel <= 1'b1;
    test_end("pin_select");
    // Soft reset restores flags, mask and high performance codes; the link
    // goes down first, since power settings may only change with it off
    link_en <= 1'b0;
    wr(`ASP_ADDR_LP_C, 8'h00);
    wr(`ASP_ADDR_LP_D, 8'h14);
    soft_reset <= 1'b1;
    @(posedge mclk);
    soft_reset <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK(code_c, 8'h04)
    `CHK(code_d, 8'h1b)
    rd(`ASP_ADDR_FLAGS);
    `CHK(rdat, 8'h3f)
    rd(`ASP_ADDR_MASK);
    `CHK(rdat, 8'h3f)
    test_end("soft_reset");
    finish_test();
  end

endmodule
